// >>> common/usmc_pkg.sv
// constants, states and bit layout shared by both ends of the serial unit
// assumes one 200 MHz clock and an 8-bit register port on 16-bit addresses
package usmc_pkg;
  localparam int AW = 16;
  localparam int DW = 8;
  localparam int P3_W = 7;
  // register addresses
  localparam logic [15:0] ADR_P3_DIR = 16'hff23;
  localparam logic [15:0] ADR_MODE = 16'hff90;
  localparam logic [15:0] ADR_TRMC = 16'hff91;
  localparam logic [15:0] ADR_BRGC = 16'hff92;
  localparam logic [15:0] ADR_CKSEL = 16'hff93;
  localparam logic [15:0] ADR_TXB = 16'hff94;
  localparam logic [15:0] ADR_RXB = 16'hff95;
  localparam logic [15:0] ADR_RXSTAT = 16'hff96;
  localparam logic [15:0] ADR_TXSTAT = 16'hff97;
  localparam logic [15:0] ADR_P3_LATCH = 16'hff03;
  // values after reset, and the TRMC write mask
  localparam logic [7:0] RST_P3_DIR = 8'hff;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_TRMC = 8'h02;
  localparam logic [7:0] RST_BRGC = 8'hff;
  localparam logic [7:0] RST_CKSEL = 8'h00;
  localparam logic [7:0] RST_P3_LATCH = 8'h00;
  localparam logic [7:0] TRMC_WMASK = 8'hcb;
  // field positions
  localparam int B_PWR = 7;
  localparam int B_TXE = 6;
  localparam int B_RXE = 5;
  localparam int B_CL = 2;
  localparam int B_SL = 1;
  localparam int B_ISEM = 0;
  localparam int B_ISMD = 3;
  localparam int B_EXT = 3;
  localparam int PIN_TX = 4;
  localparam int PIN_RX = 5;
  localparam int PIN_EXT = 6;
  // host bring-up and shut-down values
  localparam logic [7:0] HOST_DIR = 8'hef;
  localparam logic [7:0] HOST_LATCH = 8'h00;
  localparam int STOP_WAIT_CLKS = 2;
  // 200 MHz / (2^(6+1) * 50) = 31.25 kbps
  localparam logic [2:0] MIDI_N = 3'h6;
  localparam logic [7:0] MIDI_K = 8'h32;
  localparam logic [3:0] STEP_RUN = 4'h8;
  localparam logic [3:0] STEP_STOP = 4'h9;
  localparam logic [3:0] STEP_OFF = 4'ha;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} usmc_tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} usmc_rx_e;
  typedef enum logic [1:0] {H_IDLE, H_SEQ, H_WAIT} usmc_host_e;
endpackage

// >>> common/usmc_if.sv
// register port between the controlling software end and the serial unit
// both ends run on the same clock; rdata answers one cycle after rd
`timescale 1ns/1ps
interface usmc_if;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic tx_irq;
  logic rx_irq;
  modport dev (input addr, wdata, wr, rd, output rdata, tx_irq, rx_irq);
  modport sw (output addr, wdata, wr, rd, input rdata, tx_irq, rx_irq);
endinterface

// >>> logic/usmc_dev.sv
// serial unit: mode control, baud generator, transmitter, receiver, port 3
// assumes software on the register port and a remote transceiver on pins
`timescale 1ns/1ps
module usmc_dev (
  input wire logic clk,
  input wire logic rst,
  usmc_if.dev bus,
  input wire logic [usmc_pkg::P3_W-1:0] p3_in,
  output logic [usmc_pkg::P3_W-1:0] p3_out,
  output logic [usmc_pkg::P3_W-1:0] p3_oe_n
);
  import usmc_pkg::*;

  logic [7:0] dir_r, dir_nxt, mode_r, mode_nxt, trmc_r, trmc_nxt;
  logic [7:0] brgc_r, brgc_nxt, cksel_r, cksel_nxt, latch_r, latch_nxt;
  logic [7:0] txb_r, txb_nxt, rdata_r, rdata_nxt;
  logic txb_full_r, txb_full_nxt;
  logic [6:0] pin_s1_r, pin_s2_r, p3_out_r, p3_out_nxt, p3_oe_r;
  logic ext_d_r;
  logic [6:0] pre_r, pre_nxt;
  logic [7:0] kcnt_r, kcnt_nxt;
  logic half_r, half_nxt;
  usmc_tx_e tx_st_r, tx_st_nxt;
  logic [7:0] tx_sh_r, tx_sh_nxt;
  logic [2:0] tx_cnt_r, tx_cnt_nxt;
  logic tx_ph_r, tx_ph_nxt, tx_o_r, tx_o_nxt, tx_irq_r, tx_irq_nxt;
  logic tx_load;
  usmc_rx_e rx_st_r, rx_st_nxt;
  logic [7:0] rx_sh_r, rx_sh_nxt, rxb_r, rxb_nxt;
  logic [2:0] rx_cnt_r, rx_cnt_nxt;
  logic rx_ph_r, rx_ph_nxt, ferr_r, ferr_nxt, rx_irq_r, rx_irq_nxt;
  logic pwr, txe, rxe, wr_txb, rd_rxst, src_tick, bit_end;
  logic [2:0] last_bit;

  assign pwr = mode_r[B_PWR];
  assign txe = mode_r[B_TXE];
  assign rxe = mode_r[B_RXE];
  assign last_bit = mode_r[B_CL] ? 3'h7 : 3'h6;
  assign wr_txb = bus.wr && bus.addr == ADR_TXB;
  assign rd_rxst = bus.rd && bus.addr == ADR_RXSTAT;
  assign bit_end = half_r && tx_ph_r;
  assign p3_out = p3_out_r;
  assign p3_oe_n = p3_oe_r;
  assign bus.rdata = rdata_r;
  assign bus.tx_irq = tx_irq_r;
  assign bus.rx_irq = rx_irq_r;

  // register file
  always_comb begin
    dir_nxt = dir_r;
    mode_nxt = mode_r;
    trmc_nxt = trmc_r;
    brgc_nxt = brgc_r;
    cksel_nxt = cksel_r;
    latch_nxt = latch_r;
    txb_nxt = txb_r;
    txb_full_nxt = txb_full_r && !tx_load;
    rdata_nxt = rdata_r;
    if (bus.wr) begin
      case (bus.addr)
        ADR_P3_DIR: dir_nxt = {1'b1, bus.wdata[6:0]};
        ADR_MODE: mode_nxt = bus.wdata;
        ADR_TRMC: trmc_nxt = bus.wdata & TRMC_WMASK;
        ADR_BRGC: brgc_nxt = bus.wdata;
        ADR_CKSEL: cksel_nxt = bus.wdata;
        ADR_P3_LATCH: latch_nxt = bus.wdata;
        default: ;
      endcase
    end
    // buffer takes data only while powered and enabled
    if (wr_txb && pwr && txe && !txb_full_r) begin
      txb_nxt = bus.wdata;
      txb_full_nxt = 1'b1;
    end
    if (!pwr || !txe) begin
      txb_full_nxt = 1'b0;
    end
    if (bus.rd) begin
      case (bus.addr)
        ADR_P3_DIR: rdata_nxt = {1'b1, dir_r[6:0]};
        ADR_MODE: rdata_nxt = mode_r;
        ADR_TRMC: rdata_nxt = trmc_r;
        ADR_BRGC: rdata_nxt = brgc_r;
        ADR_CKSEL: rdata_nxt = cksel_r;
        ADR_P3_LATCH: rdata_nxt = {1'b0,
          (dir_r[6:0] & pin_s2_r) | (~dir_r[6:0] & latch_r[6:0])};
        ADR_TXB: rdata_nxt = txb_r;
        ADR_RXB: rdata_nxt = rxb_r;
        ADR_RXSTAT: rdata_nxt = {7'h00, ferr_r};
        ADR_TXSTAT: rdata_nxt = {6'h00, txb_full_r, tx_st_r != TX_IDLE};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dir_r <= RST_P3_DIR;
      mode_r <= RST_MODE;
      trmc_r <= RST_TRMC;
      brgc_r <= RST_BRGC;
      cksel_r <= RST_CKSEL;
      latch_r <= RST_P3_LATCH;
      txb_r <= 8'h00;
      txb_full_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      dir_r <= dir_nxt;
      mode_r <= mode_nxt;
      trmc_r <= trmc_nxt;
      brgc_r <= brgc_nxt;
      cksel_r <= cksel_nxt;
      latch_r <= latch_nxt;
      txb_r <= txb_nxt;
      txb_full_r <= txb_full_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // pins: two-stage sync, port mux
  always_comb begin
    p3_out_nxt = latch_r[6:0];
    // serial line replaces latch only for an enabled direction
    if (txe) begin
      p3_out_nxt[PIN_TX] = tx_o_r;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1_r <= 7'h00;
      pin_s2_r <= 7'h00;
      ext_d_r <= 1'b0;
      p3_out_r <= 7'h00;
      p3_oe_r <= 7'h7f;
    end else begin
      pin_s1_r <= p3_in;
      pin_s2_r <= pin_s1_r;
      ext_d_r <= pin_s2_r[PIN_EXT];
      p3_out_r <= p3_out_nxt;
      p3_oe_r <= dir_r[6:0];
    end
  end

  // baud generator: half-bit tick at src / (2^n * k)
  always_comb begin
    src_tick = cksel_r[B_EXT] ? (pin_s2_r[PIN_EXT] && !ext_d_r) : 1'b1;
    pre_nxt = pre_r;
    kcnt_nxt = kcnt_r;
    half_nxt = 1'b0;
    if (!pwr) begin
      pre_nxt = 7'h00;
      kcnt_nxt = 8'h00;
    end else if (src_tick) begin
      if (pre_r == 7'((8'h01 << cksel_r[2:0]) - 8'h01)) begin
        pre_nxt = 7'h00;
        // k and n cover 200 MHz down to 31.25 kbps
        if (kcnt_r >= brgc_r - 8'h01) begin
          kcnt_nxt = 8'h00;
          half_nxt = 1'b1;
        end else begin
          kcnt_nxt = kcnt_r + 8'h01;
        end
      end else begin
        pre_nxt = pre_r + 7'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_r <= 7'h00;
      kcnt_r <= 8'h00;
      half_r <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      kcnt_r <= kcnt_nxt;
      half_r <= half_nxt;
    end
  end

  // transmitter
  always_comb begin
    tx_st_nxt = tx_st_r;
    tx_sh_nxt = tx_sh_r;
    tx_cnt_nxt = tx_cnt_r;
    tx_ph_nxt = half_r ? !tx_ph_r : tx_ph_r;
    tx_o_nxt = tx_o_r;
    tx_irq_nxt = 1'b0;
    tx_load = 1'b0;
    if (!pwr) begin
      tx_st_nxt = TX_IDLE;
      tx_o_nxt = 1'b0;
      tx_ph_nxt = 1'b0;
    end else if (!txe) begin
      tx_st_nxt = TX_IDLE;
      tx_o_nxt = 1'b1;
      tx_ph_nxt = 1'b0;
    end else begin
      case (tx_st_r)
        TX_IDLE: begin
          tx_o_nxt = 1'b1;
          if (txb_full_r && half_r) begin
            tx_load = 1'b1;
            tx_sh_nxt = txb_r;
            tx_o_nxt = 1'b0;
            tx_ph_nxt = 1'b0;
            tx_st_nxt = TX_START;
            tx_irq_nxt = trmc_r[B_ISMD];
          end
        end
        TX_START: if (bit_end) begin
          tx_o_nxt = tx_sh_r[0];
          tx_cnt_nxt = 3'h0;
          tx_st_nxt = TX_DATA;
        end
        TX_DATA: if (bit_end) begin
          if (tx_cnt_r == last_bit) begin
            tx_o_nxt = 1'b1;
            tx_cnt_nxt = 3'h0;
            tx_st_nxt = TX_STOP;
          end else begin
            tx_sh_nxt = {1'b0, tx_sh_r[7:1]};
            tx_o_nxt = tx_sh_r[1];
            tx_cnt_nxt = tx_cnt_r + 3'h1;
          end
        end
        TX_STOP: if (bit_end) begin
          if (mode_r[B_SL] && tx_cnt_r == 3'h0) begin
            tx_cnt_nxt = 3'h1;
          end else begin
            tx_st_nxt = TX_IDLE;
            tx_irq_nxt = !trmc_r[B_ISMD];
          end
        end
        default: tx_st_nxt = TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_st_r <= TX_IDLE;
      tx_sh_r <= 8'h00;
      tx_cnt_r <= 3'h0;
      tx_ph_r <= 1'b0;
      tx_o_r <= 1'b0;
      tx_irq_r <= 1'b0;
    end else begin
      tx_st_r <= tx_st_nxt;
      tx_sh_r <= tx_sh_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      tx_ph_r <= tx_ph_nxt;
      tx_o_r <= tx_o_nxt;
      tx_irq_r <= tx_irq_nxt;
    end
  end

  // receiver: one stop bit checked whatever the stop setting
  always_comb begin
    rx_st_nxt = rx_st_r;
    rx_sh_nxt = rx_sh_r;
    rx_cnt_nxt = rx_cnt_r;
    rx_ph_nxt = half_r ? !rx_ph_r : rx_ph_r;
    rxb_nxt = rxb_r;
    ferr_nxt = ferr_r && !rd_rxst;
    rx_irq_nxt = 1'b0;
    if (!pwr) begin
      rx_st_nxt = RX_IDLE;
      rxb_nxt = 8'h00;
      ferr_nxt = 1'b0;
    end else if (!rxe) begin
      rx_st_nxt = RX_IDLE;
    end else begin
      case (rx_st_r)
        RX_IDLE: if (!pin_s2_r[PIN_RX]) begin
          rx_st_nxt = RX_START;
        end
        RX_START: if (half_r) begin
          rx_ph_nxt = 1'b0;
          rx_cnt_nxt = 3'h0;
          rx_st_nxt = pin_s2_r[PIN_RX] ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (half_r && rx_ph_r) begin
          rx_sh_nxt = {pin_s2_r[PIN_RX], rx_sh_r[7:1]};
          rx_cnt_nxt = rx_cnt_r + 3'h1;
          if (rx_cnt_r == last_bit) begin
            rx_st_nxt = RX_STOP;
          end
        end
        RX_STOP: if (half_r && rx_ph_r) begin
          rxb_nxt = mode_r[B_CL] ? rx_sh_r : {1'b0, rx_sh_r[7:1]};
          rx_st_nxt = RX_IDLE;
          if (!pin_s2_r[PIN_RX]) begin
            ferr_nxt = 1'b1;
            rx_irq_nxt = !mode_r[B_ISEM];
          end else begin
            rx_irq_nxt = 1'b1;
          end
        end
        default: rx_st_nxt = RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_st_r <= RX_IDLE;
      rx_sh_r <= 8'h00;
      rx_cnt_r <= 3'h0;
      rx_ph_r <= 1'b0;
      rxb_r <= 8'h00;
      ferr_r <= 1'b0;
      rx_irq_r <= 1'b0;
    end else begin
      rx_st_r <= rx_st_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      rx_ph_r <= rx_ph_nxt;
      rxb_r <= rxb_nxt;
      ferr_r <= ferr_nxt;
      rx_irq_r <= rx_irq_nxt;
    end
  end
endmodule

// >>> logic/usmc_host.sv
// controlling end: brings the serial unit up, sends bytes, shuts it down
// assumes the unit answers on the shared register port in the same clock
`timescale 1ns/1ps
module usmc_host (
  input wire logic clk,
  input wire logic rst,
  usmc_if.sw bus,
  input wire logic cfg_go,
  input wire logic [3:0] cfg_clk_sel,
  input wire logic [7:0] cfg_baud_div,
  input wire logic [4:0] cfg_fmt,
  input wire logic cfg_irq_src,
  input wire logic send_go,
  input wire logic [7:0] send_byte,
  input wire logic stop_go,
  output logic busy,
  output logic tx_done,
  output logic rx_done
);
  import usmc_pkg::*;

  usmc_host_e st_r, st_nxt;
  logic [3:0] idx_r, idx_nxt, cks_r, cks_nxt;
  logic [7:0] brg_r, brg_nxt, tmp;
  logic [4:0] fmt_r, fmt_nxt;
  logic src_r, src_nxt;
  logic [17:0] wait_r, wait_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic wr_r, wr_nxt, busy_r, tx_done_r, rx_done_r;

  // one write of the bring-up and shut-down walk
  function automatic logic [23:0] step_wr(input logic [3:0] i,
      input logic [3:0] cks, input logic [7:0] brg,
      input logic [4:0] fmt, input logic src);
    case (i)
      4'h0: step_wr = {ADR_P3_LATCH, HOST_LATCH};
      4'h1: step_wr = {ADR_P3_DIR, HOST_DIR};
      4'h2: step_wr = {ADR_CKSEL, 4'h0, cks};
      4'h3: step_wr = {ADR_BRGC, brg};
      4'h4: step_wr = {ADR_TRMC, 4'h0, src, 3'h0};
      4'h5: step_wr = {ADR_MODE, 3'h0, fmt};
      4'h6: step_wr = {ADR_MODE, 3'h4, fmt};
      4'h7: step_wr = {ADR_MODE, 3'h6, fmt};
      4'h8: step_wr = {ADR_MODE, 3'h7, fmt};
      4'h9: step_wr = {ADR_MODE, 3'h4, fmt};
      default: step_wr = {ADR_MODE, 8'h00};
    endcase
  endfunction

  assign bus.addr = addr_r;
  assign bus.wdata = wdata_r;
  assign bus.wr = wr_r;
  assign bus.rd = 1'b0;
  assign busy = busy_r;
  assign tx_done = tx_done_r;
  assign rx_done = rx_done_r;

  always_comb begin
    st_nxt = st_r;
    idx_nxt = idx_r;
    cks_nxt = cks_r;
    brg_nxt = brg_r;
    fmt_nxt = fmt_r;
    src_nxt = src_r;
    wait_nxt = wait_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    wr_nxt = 1'b0;
    tmp = 8'h00;
    case (st_r)
      H_IDLE: begin
        if (cfg_go) begin
          cks_nxt = cfg_clk_sel;
          brg_nxt = cfg_baud_div;
          fmt_nxt = cfg_fmt;
          src_nxt = cfg_irq_src;
          idx_nxt = 4'h0;
          st_nxt = H_SEQ;
        end else if (stop_go) begin
          idx_nxt = STEP_STOP;
          st_nxt = H_SEQ;
        end else if (send_go) begin
          addr_nxt = ADR_TXB;
          wdata_nxt = send_byte;
          wr_nxt = 1'b1;
        end
      end
      H_SEQ: begin
        {addr_nxt, wdata_nxt} = step_wr(idx_r, cks_r, brg_r, fmt_r, src_r);
        wr_nxt = 1'b1;
        idx_nxt = idx_r + 4'h1;
        if (idx_r == STEP_RUN || idx_r == STEP_OFF) begin
          st_nxt = H_IDLE;
        end else if (idx_r == STEP_STOP) begin
          // two half-bit clocks = 2 * 2^n * k cycles
          tmp = brg_r;
          wait_nxt = 18'(({10'h000, tmp} << cks_r[2:0]) * STOP_WAIT_CLKS);
          st_nxt = H_WAIT;
        end
      end
      H_WAIT: begin
        if (wait_r == 18'h00000) begin
          st_nxt = H_SEQ;
        end else begin
          wait_nxt = wait_r - 18'h00001;
        end
      end
      default: st_nxt = H_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= H_IDLE;
      idx_r <= 4'h0;
      cks_r <= 4'h0;
      brg_r <= MIDI_K;
      fmt_r <= 5'h00;
      src_r <= 1'b0;
      wait_r <= 18'h00000;
      addr_r <= 16'h0000;
      wdata_r <= 8'h00;
      wr_r <= 1'b0;
      busy_r <= 1'b0;
      tx_done_r <= 1'b0;
      rx_done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      idx_r <= idx_nxt;
      cks_r <= cks_nxt;
      brg_r <= brg_nxt;
      fmt_r <= fmt_nxt;
      src_r <= src_nxt;
      wait_r <= wait_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      wr_r <= wr_nxt;
      busy_r <= st_nxt != H_IDLE;
      tx_done_r <= bus.tx_irq;
      rx_done_r <= bus.rx_irq;
    end
  end
endmodule

// >>> test/usmc_checker.sv
// concurrent checks on the register port and port-3 pins of the unit
// assumes one clock domain, async active-high reset, host writes only
`timescale 1ns/1ps
module usmc_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic tx_irq,
  input wire logic rx_irq,
  input wire logic [usmc_pkg::P3_W-1:0] p3_out,
  input wire logic [usmc_pkg::P3_W-1:0] p3_oe_n
);
  import usmc_pkg::*;
  logic [7:0] mode_r, mode_nxt, cks_r, cks_nxt, brg_r, brg_nxt;
  logic [15:0] gap_r, gap_nxt, need;
  logic [1:0] off_r, off_nxt;

  // shadows of the mode, clock select and divider writes
  always_comb begin
    mode_nxt = mode_r;
    cks_nxt = cks_r;
    brg_nxt = brg_r;
    gap_nxt = (gap_r == 16'hffff) ? gap_r : gap_r + 16'h1;
    off_nxt = (mode_r[7:5] != 3'h0) ? 2'h0 :
              (off_r == 2'h3) ? off_r : off_r + 2'h1;
    if (wr && addr == ADR_MODE) begin
      mode_nxt = wdata;
      gap_nxt = 16'h0;
    end
    if (wr && addr == ADR_CKSEL) cks_nxt = wdata;
    if (wr && addr == ADR_BRGC) brg_nxt = wdata;
  end
  assign need = 16'h2 * (16'h1 << cks_r[2:0]) * {8'h0, brg_r};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_r <= RST_MODE;
      cks_r <= RST_CKSEL;
      brg_r <= RST_BRGC;
      gap_r <= 16'h0;
      off_r <= 2'h0;
    end else begin
      mode_r <= mode_nxt;
      cks_r <= cks_nxt;
      brg_r <= brg_nxt;
      gap_r <= gap_nxt;
      off_r <= off_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_setup;
    wr && addr == ADR_P3_DIR ##1 wr && addr == ADR_CKSEL
    ##1 wr && addr == ADR_BRGC
    ##1 wr && addr == ADR_TRMC && wdata[7:6] == 2'b00;
  endsequence
  sequence s_enable;
    wr && addr == ADR_MODE && wdata[7:5] == 3'h0
    ##1 wr && addr == ADR_MODE && wdata[7:5] == 3'h4
    ##1 wr && addr == ADR_MODE && wdata[7:5] == 3'h6
    ##1 wr && addr == ADR_MODE && wdata[7:5] == 3'h7;
  endsequence

  a_reset_state: assert property ($fell(rst) |-> p3_oe_n == 7'h7f
    && p3_out == 7'h00 && !tx_irq && !rx_irq)
    else $error("pins or irqs wrong after reset");
  a_dir_follow: assert property (wr && addr == ADR_P3_DIR |->
    ##2 p3_oe_n == $past(wdata[P3_W-1:0], 2))
    else $error("pin enables do not follow direction write");
  a_idle_mark: assert property (wr && addr == ADR_MODE
    && wdata[7:6] == 2'b11 |-> ##3 p3_out[PIN_TX] [*4])
    else $error("enabled transmit line not at mark");
  a_power_low: assert property (wr && addr == ADR_MODE
    && wdata[7:5] == 3'h0 |-> ##3 !p3_out[PIN_TX] [*4])
    else $error("transmit line not low with power off");
  a_tx_refused: assert property (wr && addr == ADR_TXB
    && mode_r[7:6] != 2'b11 |=> $stable(p3_out[PIN_TX]) [*8])
    else $error("disabled unit started a frame");
  a_stop_quiet: assert property (off_r == 2'h3 |-> !tx_irq && !rx_irq)
    else $error("irq while in stop mode");
  a_stop_wait: assert property (wr && addr == ADR_MODE
    && !wdata[B_PWR] && mode_r[B_PWR] |-> gap_r >= need)
    else $error("power cleared too soon after disable");
  a_bring_order: assert property (wr && addr == ADR_P3_LATCH
    |=> s_setup ##1 s_enable)
    else $error("bring-up writes out of order");
  a_irq_pulse: assert property (tx_irq |=> !tx_irq)
    else $error("transmit irq longer than one cycle");
endmodule

// >>> test/usmc_tb_top.sv
// bench joining host and unit, transmit looped back to receive
// assumes 200 MHz clock and host-driven register port
`timescale 1ns/1ps
module usmc_tb_top;
  import usmc_pkg::*;
  logic clk, rst, cfg_go, cfg_irq_src, send_go, stop_go;
  logic [3:0] cfg_clk_sel;
  logic [7:0] cfg_baud_div, send_byte;
  logic [4:0] cfg_fmt;
  logic busy, tx_done, rx_done, tx_seen, rx_seen, seen_clr;
  logic [P3_W-1:0] p3_in, p3_out, p3_oe_n;
  int error_cnt, tests_run, bt;

  usmc_if link ();
  assign p3_in = {1'b1, p3_out[PIN_TX], 5'h1f};
  usmc_dev u_usmc_dev (.clk(clk), .rst(rst), .bus(link.dev),
    .p3_in(p3_in), .p3_out(p3_out), .p3_oe_n(p3_oe_n));
  usmc_host u_usmc_host (.clk(clk), .rst(rst), .bus(link.sw),
    .cfg_go(cfg_go), .cfg_clk_sel(cfg_clk_sel),
    .cfg_baud_div(cfg_baud_div), .cfg_fmt(cfg_fmt),
    .cfg_irq_src(cfg_irq_src), .send_go(send_go), .send_byte(send_byte),
    .stop_go(stop_go), .busy(busy), .tx_done(tx_done), .rx_done(rx_done));
  usmc_checker u_usmc_checker (.clk(clk), .rst(rst), .addr(link.addr),
    .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata),
    .tx_irq(link.tx_irq), .rx_irq(link.rx_irq), .p3_out(p3_out),
    .p3_oe_n(p3_oe_n));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // irq catchers, cleared on request from the send task
  always @(posedge clk) begin
    if (seen_clr) begin
      tx_seen <= 1'b0;
      rx_seen <= 1'b0;
    end else begin
      if (tx_done) tx_seen <= 1'b1;
      if (rx_done) rx_seen <= 1'b1;
    end
  end

  task automatic chk1(string what, logic exp, logic got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk7(string what, logic [6:0] exp, logic [6:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 20000 && busy !== 1'b0; i++) @(negedge clk);
    chk1("busy", 1'b0, busy);
  endtask

  task automatic configure(logic [3:0] cs, logic [7:0] k, logic [4:0] f,
                           logic src);
    @(negedge clk);
    cfg_clk_sel = cs;
    cfg_baud_div = k;
    cfg_fmt = f;
    cfg_irq_src = src;
    cfg_go = 1'b1;
    @(negedge clk);
    cfg_go = 1'b0;
    bt = 2 * (1 << cs[2:0]) * k;
    wait_idle();
    // last enable write still travels through mode, line and pin flops
    repeat (4) @(negedge clk);
    chk7("pin enables", 7'h6f, p3_oe_n);
    chk1("idle line", 1'b1, p3_out[PIN_TX]);
  endtask

  task automatic send(logic [7:0] b);
    @(negedge clk);
    seen_clr = 1'b1;
    send_byte = b;
    send_go = 1'b1;
    @(negedge clk);
    send_go = 1'b0;
    seen_clr = 1'b0;
  endtask

  task automatic shutdown();
    @(negedge clk);
    stop_go = 1'b1;
    @(negedge clk);
    stop_go = 1'b0;
    wait_idle();
    repeat (4) @(negedge clk);
    chk1("line off", 1'b0, p3_out[PIN_TX]);
  endtask

  // sample each bit at its centre, lsb first
  task automatic frame(logic [7:0] b, int nb, logic src);
    int i;
    i = 0;
    while (p3_out[PIN_TX] !== 1'b0 && i < 3 * bt) begin
      @(negedge clk);
      i++;
    end
    repeat (bt / 2) @(negedge clk);
    chk1("start bit", 1'b0, p3_out[PIN_TX]);
    for (i = 0; i < nb; i++) begin
      repeat (bt) @(negedge clk);
      chk1("data bit", b[i], p3_out[PIN_TX]);
    end
    repeat (bt) @(negedge clk);
    chk1("stop bit", 1'b1, p3_out[PIN_TX]);
    chk1("tx irq early", src, tx_seen);
    repeat (bt) @(negedge clk);
    chk1("tx irq", 1'b1, tx_seen);
    chk1("rx irq", 1'b1, rx_seen);
  endtask

  initial begin
    repeat (95000) @(posedge clk);
    error_cnt++;
    $display("Error watchdog expected finish seen timeout");
    summarize();
  end

  initial begin
    rst = 1'b1;
    cfg_go = 1'b0;
    cfg_clk_sel = 4'h0;
    cfg_baud_div = 8'h08;
    cfg_fmt = 5'h00;
    cfg_irq_src = 1'b0;
    send_go = 1'b0;
    send_byte = 8'h00;
    stop_go = 1'b0;
    seen_clr = 1'b1;
    error_cnt = 0;
    tests_run = 0;
    bt = 16;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk7("reset enables", 7'h7f, p3_oe_n);
    chk1("reset busy", 1'b0, busy);
    // buffer write while stopped must be ignored
    send(8'h55);
    repeat (100) @(negedge clk);
    chk1("stopped irq", 1'b0, tx_seen);
    chk1("stopped line", 1'b0, p3_out[PIN_TX]);
    configure(4'h0, 8'h08, 5'h04, 1'b0);
    send(8'ha5);
    frame(8'ha5, 8, 1'b0);
    shutdown();
    // 31.25 kbps, seven-bit characters, irq on buffer transfer
    configure({1'b0, MIDI_N}, MIDI_K, 5'h00, 1'b1);
    send(8'h36);
    frame(8'h36, 7, 1'b1);
    shutdown();
    summarize();
  end
endmodule
